// ==== core/ccp_pkg.sv ====
package ccp_pkg;
    // system clock
    localparam int CLK_MHZ = 100;
    // one unit interval of the coded stream, in ns (300 kbit/s nominal)
    localparam int UI_NS = 3333;
    localparam int UI_CYC_I = (UI_NS * CLK_MHZ) / 1000;
    localparam logic [9:0] UI_CYC = 10'(UI_CYC_I);
    localparam logic [9:0] HALF_CYC = 10'(UI_CYC_I / 2);
    localparam logic [9:0] SECOND_CYC = 10'(UI_CYC_I - UI_CYC_I / 2);
    // decode threshold: three quarters of a unit interval
    localparam logic [9:0] THREEQ_CYC = 10'((UI_CYC_I * 3) / 4);
    // receiver gives up on a frame after two silent unit intervals
    localparam logic [9:0] IDLE_CYC = 10'(UI_CYC_I * 2);

    // termination codes reported by the analog comparators per line
    localparam logic [1:0] TERM_OPEN = 2'h0;
    localparam logic [1:0] TERM_RD = 2'h1;
    localparam logic [1:0] TERM_RA = 2'h2;

    // advertised source current codes
    localparam logic [1:0] ADV_DEFAULT = 2'h0;
    localparam logic [1:0] ADV_1A5 = 2'h1;
    localparam logic [1:0] ADV_3A0 = 2'h2;

    // reset values
    localparam logic [3:0] PEAK_RST = 4'h0;
    localparam logic [1:0] ADV_RST = ADV_DEFAULT;

    // transmit fifo shape
    localparam int FIFO_WIDTH = 2;
    localparam int FIFO_DEPTH = 16;

    // bit positions in the synchronised input vector
    localparam int SYN_W = 7;
    localparam int SYN_CC1 = 0;
    localparam int SYN_CC2 = 1;
    localparam int SYN_T1 = 2;
    localparam int SYN_T2 = 4;
    localparam int SYN_VBUS = 6;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_LEAD,
        TX_FIRST,
        TX_SECOND,
        TX_TAIL
    } ccp_tx_e;

    typedef enum logic [3:0] {
        CONN_NONE,
        CONN_UFP1,
        CONN_UFP2,
        CONN_CABLE1,
        CONN_CABLE2,
        CONN_PWR1,
        CONN_PWR2,
        CONN_DEBUG,
        CONN_AUDIO,
        CONN_SINK
    } ccp_conn_e;
endpackage

// ==== core/ccp_fifo.sv ====
`timescale 1ns/1ps
module ccp_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ccp_fifo_s;

    ccp_fifo_s st;
    ccp_fifo_s next_st;
    logic push;
    logic pop;

    assign in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==== core/ccp_phy_top.sv ====
// Functional notes
// - every bit cell starts with a line transition, whatever the bit value.
// - a one adds a mid-cell transition; a zero has only the boundary edge.
// - a frame starts by driving the line low before any coded edge.
// - receiver locks even if the first edge of a frame is missed.
// - after the final bit one terminating edge is sent.
// - drive the active line only while sending, release it afterwards.
// - send and receive only on the line chosen by orientation detection.
// - at most one party drives the line; idle parties are high impedance.
// - transmit peak level is settable by firmware configuration.
// - both lines open: keep watching both, no VBUS nor VCONN.
// - Rd on one, other open: VBUS on, no VCONN, watch the Rd line.
// - Ra on one, other open: watch both roles, VBUS and VCONN off.
// - Ra and Rd: VBUS on, VCONN onto Ra line, watch only Rd line.
// - Rd/Rd is debug, Ra/Ra audio accessory; detach on either ends it.
// - once connected, a watched line leaving its termination means detach; debug and audio end only when a line goes open.
// - source advertises default, 1.5 A or 3 A through its pull-up.
// - as sink present Rd, attach on VBUS, infer current from far pull-up.
`timescale 1ns/1ps
module ccp_phy_top (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // transmit stream
    input wire logic TX_VALID,
    output logic TX_READY,
    input wire logic TX_BIT,
    input wire logic TX_LAST,
    output logic TX_BUSY,
    // receive stream
    output logic RX_VALID,
    output logic RX_BIT,
    output logic RX_ACTIVE,
    // configuration line one
    input wire logic CC1_I,
    output logic CC1_O,
    output logic CC1_OE_N,
    // configuration line two
    input wire logic CC2_I,
    output logic CC2_O,
    output logic CC2_OE_N,
    // termination sensing
    input wire logic [1:0] CC1_TERM,
    input wire logic [1:0] CC2_TERM,
    input wire logic VBUS_PRESENT,
    // firmware configuration
    input wire logic [3:0] TX_PEAK_CFG,
    input wire logic [1:0] ADV_CURRENT_CFG,
    input wire logic SINK_MODE,
    input wire logic [1:0] FAR_RP_LEVEL,
    // analog control
    output logic [3:0] TX_PEAK_LEVEL,
    output logic [1:0] RP_LEVEL,
    output logic RD_PRESENT,
    output logic VBUS_EN,
    output logic VCONN_CC1_EN,
    output logic VCONN_CC2_EN,
    // connection status
    output logic ORIENT,
    output logic [3:0] CONN_STATE,
    output logic [1:0] RP_INFERRED,
    output logic ATTACH_EVT,
    output logic DETACH_EVT,
    input wire logic ATTACH_CLR,
    input wire logic DETACH_CLR
);
    typedef struct packed {
        logic [ccp_pkg::SYN_W-1:0] s1;
        logic [ccp_pkg::SYN_W-1:0] s2;
        logic [ccp_pkg::SYN_W-1:0] s3;
        logic [ccp_pkg::SYN_W-1:0] filt;
        ccp_pkg::ccp_tx_e tx_st;
        logic [9:0] tx_cnt;
        logic tx_lvl;
        logic tx_drive;
        logic tx_bit;
        logic tx_last;
        logic rx_lvl;
        logic [9:0] rx_cnt;
        logic rx_lock;
        logic rx_half;
        logic rx_bit;
        logic rx_valid;
        ccp_pkg::ccp_conn_e conn;
        logic attach_evt;
        logic detach_evt;
        logic [3:0] peak;
        logic [1:0] adv;
        logic sink;
        logic [1:0] rp_inf;
    } ccp_top_s;

    ccp_top_s st;
    ccp_top_s next_st;

    logic fifo_valid;
    logic fifo_pop;
    logic [1:0] fifo_data;
    logic orient;
    logic can_talk;
    logic [1:0] t1;
    logic [1:0] t2;
    logic line_now;

    ccp_fifo #(
        .WIDTH(ccp_pkg::FIFO_WIDTH),
        .DEPTH(ccp_pkg::FIFO_DEPTH)
    ) u_txq (
        .clk(MCLK),
        .rst(RESET),
        .in_valid(TX_VALID),
        .in_ready(TX_READY),
        .in_data({TX_LAST, TX_BIT}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    assign t1 = st.filt[ccp_pkg::SYN_T1 +: 2];
    assign t2 = st.filt[ccp_pkg::SYN_T2 +: 2];

    // data rides on the line that carries the attach bias (Rd side, or Rp side as sink)
    always_comb begin
        orient = 1'b0;
        can_talk = 1'b1;
        unique case (st.conn)
            ccp_pkg::CONN_UFP2, ccp_pkg::CONN_PWR1: orient = 1'b1;
            ccp_pkg::CONN_SINK: orient = (t2 != ccp_pkg::TERM_OPEN);
            ccp_pkg::CONN_UFP1, ccp_pkg::CONN_PWR2, ccp_pkg::CONN_DEBUG: orient = 1'b0;
            ccp_pkg::CONN_NONE, ccp_pkg::CONN_CABLE1, ccp_pkg::CONN_CABLE2,
            ccp_pkg::CONN_AUDIO: can_talk = 1'b0;
        endcase
    end

    assign line_now = orient ? st.filt[ccp_pkg::SYN_CC2] : st.filt[ccp_pkg::SYN_CC1];

    // pop is combinational so the bit is taken in the same cycle as the boundary edge
    assign fifo_pop = fifo_valid && ((st.tx_st == ccp_pkg::TX_LEAD && st.tx_cnt == ccp_pkg::UI_CYC - 10'h001)
        || (st.tx_st == ccp_pkg::TX_SECOND && !st.tx_last
            && st.tx_cnt == ccp_pkg::SECOND_CYC - 10'h001));

    always_comb begin
        next_st = st;
        next_st.rx_valid = 1'b0;

        // three-stage input sampling; a change counts once stages two and three agree
        next_st.s1 = {VBUS_PRESENT, CC2_TERM, CC1_TERM, CC2_I, CC1_I};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));

        next_st.peak = TX_PEAK_CFG;
        next_st.adv = ADV_CURRENT_CFG;
        next_st.sink = SINK_MODE;

        // transmitter
        next_st.tx_cnt = st.tx_cnt + 10'h001;
        unique case (st.tx_st)
            ccp_pkg::TX_IDLE: begin
                next_st.tx_cnt = '0;
                if (fifo_valid && can_talk) begin
                    next_st.tx_drive = 1'b1;
                    next_st.tx_lvl = 1'b0;
                    next_st.tx_st = ccp_pkg::TX_LEAD;
                end
            end
            ccp_pkg::TX_LEAD: begin
                if (st.tx_cnt == ccp_pkg::UI_CYC - 10'h001) begin
                    next_st.tx_bit = fifo_data[0];
                    next_st.tx_last = fifo_data[1];
                    next_st.tx_lvl = ~st.tx_lvl;
                    next_st.tx_cnt = '0;
                    next_st.tx_st = ccp_pkg::TX_FIRST;
                end
            end
            ccp_pkg::TX_FIRST: begin
                if (st.tx_cnt == ccp_pkg::HALF_CYC - 10'h001) begin
                    if (st.tx_bit) begin
                        next_st.tx_lvl = ~st.tx_lvl;
                    end
                    next_st.tx_cnt = '0;
                    next_st.tx_st = ccp_pkg::TX_SECOND;
                end
            end
            ccp_pkg::TX_SECOND: begin
                if (st.tx_cnt == ccp_pkg::SECOND_CYC - 10'h001) begin
                    next_st.tx_lvl = ~st.tx_lvl;
                    next_st.tx_cnt = '0;
                    if (fifo_pop) begin
                        next_st.tx_bit = fifo_data[0];
                        next_st.tx_last = fifo_data[1];
                        next_st.tx_st = ccp_pkg::TX_FIRST;
                    end else begin
                        // last bit or queue ran dry: this edge closes the final bit
                        next_st.tx_st = ccp_pkg::TX_TAIL;
                    end
                end
            end
            ccp_pkg::TX_TAIL: begin
                if (st.tx_cnt == ccp_pkg::HALF_CYC - 10'h001) begin
                    next_st.tx_drive = 1'b0;
                    next_st.tx_cnt = '0;
                    next_st.tx_st = ccp_pkg::TX_IDLE;
                end
            end
        endcase

        // receiver; muted while we drive so our own edges are not decoded
        if (st.tx_drive || !can_talk) begin
            next_st.rx_lock = 1'b0;
            next_st.rx_half = 1'b0;
            next_st.rx_cnt = '0;
            next_st.rx_lvl = line_now;
        end else if (line_now != st.rx_lvl) begin
            next_st.rx_lvl = line_now;
            next_st.rx_cnt = '0;
            // the first edge seen only arms timing, so a lost opening edge costs nothing
            next_st.rx_lock = 1'b1;
            if (st.rx_lock) begin
                if (st.rx_cnt < ccp_pkg::THREEQ_CYC) begin
                    next_st.rx_half = ~st.rx_half;
                    if (st.rx_half) begin
                        next_st.rx_bit = 1'b1;
                        next_st.rx_valid = 1'b1;
                    end
                end else begin
                    next_st.rx_bit = 1'b0;
                    next_st.rx_valid = 1'b1;
                    next_st.rx_half = 1'b0;
                end
            end
        end else if (st.rx_cnt == ccp_pkg::IDLE_CYC) begin
            next_st.rx_lock = 1'b0;
            next_st.rx_half = 1'b0;
        end else begin
            next_st.rx_cnt = st.rx_cnt + 10'h001;
        end

        // attach detection
        if (st.sink) begin
            next_st.rp_inf = FAR_RP_LEVEL;
        end
        unique case (st.conn)
            ccp_pkg::CONN_NONE: begin
                if (st.sink) begin
                    if (st.filt[ccp_pkg::SYN_VBUS]) begin
                        next_st.conn = ccp_pkg::CONN_SINK;
                    end
                end else if (t1 == ccp_pkg::TERM_RD && t2 == ccp_pkg::TERM_RD) begin
                    next_st.conn = ccp_pkg::CONN_DEBUG;
                end else if (t1 == ccp_pkg::TERM_RA && t2 == ccp_pkg::TERM_RA) begin
                    next_st.conn = ccp_pkg::CONN_AUDIO;
                end else if (t1 == ccp_pkg::TERM_RA && t2 == ccp_pkg::TERM_RD) begin
                    next_st.conn = ccp_pkg::CONN_PWR1;
                end else if (t1 == ccp_pkg::TERM_RD && t2 == ccp_pkg::TERM_RA) begin
                    next_st.conn = ccp_pkg::CONN_PWR2;
                end else if (t1 == ccp_pkg::TERM_RD) begin
                    next_st.conn = ccp_pkg::CONN_UFP1;
                end else if (t2 == ccp_pkg::TERM_RD) begin
                    next_st.conn = ccp_pkg::CONN_UFP2;
                end else if (t1 == ccp_pkg::TERM_RA) begin
                    next_st.conn = ccp_pkg::CONN_CABLE1;
                end else if (t2 == ccp_pkg::TERM_RA) begin
                    next_st.conn = ccp_pkg::CONN_CABLE2;
                end
                // both open: stay here and keep watching both lines
            end
            ccp_pkg::CONN_UFP1: if (t1 != ccp_pkg::TERM_RD) next_st.conn = ccp_pkg::CONN_NONE;
            ccp_pkg::CONN_UFP2: if (t2 != ccp_pkg::TERM_RD) next_st.conn = ccp_pkg::CONN_NONE;
            ccp_pkg::CONN_CABLE1: begin
                if (t1 != ccp_pkg::TERM_RA) begin
                    next_st.conn = ccp_pkg::CONN_NONE;
                end else if (t2 == ccp_pkg::TERM_RD) begin
                    next_st.conn = ccp_pkg::CONN_PWR1;
                end
            end
            ccp_pkg::CONN_CABLE2: begin
                if (t2 != ccp_pkg::TERM_RA) begin
                    next_st.conn = ccp_pkg::CONN_NONE;
                end else if (t1 == ccp_pkg::TERM_RD) begin
                    next_st.conn = ccp_pkg::CONN_PWR2;
                end
            end
            // the Ra line is not watched once VCONN powers it
            ccp_pkg::CONN_PWR1: if (t2 != ccp_pkg::TERM_RD) next_st.conn = ccp_pkg::CONN_NONE;
            ccp_pkg::CONN_PWR2: if (t1 != ccp_pkg::TERM_RD) next_st.conn = ccp_pkg::CONN_NONE;
            ccp_pkg::CONN_DEBUG, ccp_pkg::CONN_AUDIO: begin
                if (t1 == ccp_pkg::TERM_OPEN || t2 == ccp_pkg::TERM_OPEN) begin
                    next_st.conn = ccp_pkg::CONN_NONE;
                end
            end
            ccp_pkg::CONN_SINK: begin
                if (!st.filt[ccp_pkg::SYN_VBUS] || !st.sink) begin
                    next_st.conn = ccp_pkg::CONN_NONE;
                end
            end
        endcase
        // mode flip while source-connected drops the link
        if (st.sink != (st.conn == ccp_pkg::CONN_SINK) && st.conn != ccp_pkg::CONN_NONE) begin
            next_st.conn = ccp_pkg::CONN_NONE;
        end

        // event flags: a new event in the clearing cycle survives the clear
        if (ATTACH_CLR) begin
            next_st.attach_evt = 1'b0;
        end
        if (DETACH_CLR) begin
            next_st.detach_evt = 1'b0;
        end
        if (st.conn == ccp_pkg::CONN_NONE && next_st.conn != ccp_pkg::CONN_NONE) begin
            next_st.attach_evt = 1'b1;
        end
        if (st.conn != ccp_pkg::CONN_NONE && next_st.conn == ccp_pkg::CONN_NONE) begin
            next_st.detach_evt = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st <= '0;
            st.tx_st <= ccp_pkg::TX_IDLE;
            st.conn <= ccp_pkg::CONN_NONE;
            st.peak <= ccp_pkg::PEAK_RST;
            st.adv <= ccp_pkg::ADV_RST;
        end else begin
            st <= next_st;
        end
    end

    assign TX_BUSY = (st.tx_st != ccp_pkg::TX_IDLE);
    assign RX_VALID = st.rx_valid;
    assign RX_BIT = st.rx_bit;
    assign RX_ACTIVE = st.rx_lock;
    assign CC1_O = st.tx_lvl;
    assign CC2_O = st.tx_lvl;
    // only the oriented line is ever enabled, and only while a frame is out
    assign CC1_OE_N = ~(st.tx_drive && !orient);
    assign CC2_OE_N = ~(st.tx_drive && orient);
    assign TX_PEAK_LEVEL = st.peak;
    assign RP_LEVEL = st.adv;
    assign RD_PRESENT = st.sink;
    assign VBUS_EN = (st.conn == ccp_pkg::CONN_UFP1) || (st.conn == ccp_pkg::CONN_UFP2)
        || (st.conn == ccp_pkg::CONN_PWR1) || (st.conn == ccp_pkg::CONN_PWR2);
    assign VCONN_CC1_EN = (st.conn == ccp_pkg::CONN_PWR1);
    assign VCONN_CC2_EN = (st.conn == ccp_pkg::CONN_PWR2);
    assign ORIENT = orient;
    assign CONN_STATE = st.conn;
    assign RP_INFERRED = st.rp_inf;
    assign ATTACH_EVT = st.attach_evt;
    assign DETACH_EVT = st.detach_evt;
endmodule

// ==== test/ccp_phy_chk.sv ====
`timescale 1ns/1ps
module ccp_phy_chk (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESET,
    // line drive
    input wire logic TX_BUSY,
    input wire logic CC1_O,
    input wire logic CC1_OE_N,
    input wire logic CC2_OE_N,
    // configuration and status
    input wire logic [3:0] TX_PEAK_CFG,
    input wire logic [3:0] TX_PEAK_LEVEL,
    input wire logic [3:0] CONN_STATE,
    input wire logic VBUS_EN,
    input wire logic VCONN_CC1_EN,
    input wire logic VCONN_CC2_EN,
    input wire logic ATTACH_EVT,
    input wire logic ATTACH_CLR
);
    logic [9:0] gap;
    logic o_q;
    logic tog;
    assign tog = !CC1_OE_N && (CC1_O != o_q);
    // cycles since the last edge of a frame on line one
    always_ff @(posedge MCLK) begin
        o_q <= CC1_O;
        if (RESET || CC1_OE_N || tog) begin
            gap <= 10'h000;
        end else begin
            gap <= gap + 10'h001;
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    property p_one_drv; !(!CC1_OE_N && !CC2_OE_N); endproperty
    a_one_drv: assert property (p_one_drv) else $error("both lines driven");
    property p_drv_busy; (!CC1_OE_N || !CC2_OE_N) |-> TX_BUSY; endproperty
    a_drv_busy: assert property (p_drv_busy) else $error("drive outside frame");
    property p_lead_low; $fell(CC1_OE_N) |-> !CC1_O ##1 !CC1_O; endproperty
    a_lead_low: assert property (p_lead_low) else $error("frame not led low");
    property p_peak; !$past(RESET) |-> TX_PEAK_LEVEL == $past(TX_PEAK_CFG); endproperty
    a_peak: assert property (p_peak) else $error("peak level not taken");
    property p_none; CONN_STATE == 4'h0 |-> !VBUS_EN && !VCONN_CC1_EN && !VCONN_CC2_EN;
    endproperty
    a_none: assert property (p_none) else $error("power while detached");
    property p_ufp; CONN_STATE inside {4'h1, 4'h2} |-> VBUS_EN && !VCONN_CC1_EN && !VCONN_CC2_EN;
    endproperty
    a_ufp: assert property (p_ufp) else $error("sink power wrong");
    property p_cable; CONN_STATE inside {4'h3, 4'h4} |-> !VBUS_EN && !VCONN_CC1_EN && !VCONN_CC2_EN;
    endproperty
    a_cable: assert property (p_cable) else $error("power with cable only");
    property p_vconn; (VCONN_CC1_EN || VCONN_CC2_EN) |->
        VBUS_EN && (VCONN_CC1_EN ? CONN_STATE == 4'h5 : CONN_STATE == 4'h6); endproperty
    a_vconn: assert property (p_vconn) else $error("vconn on wrong line");
    property p_gap_max; !CC1_OE_N |-> gap <= 10'h154; endproperty
    a_gap_max: assert property (p_gap_max) else $error("bit boundary missing");
    property p_gap_min; tog && !$past(CC1_OE_N) |-> gap >= 10'h0A0; endproperty
    a_gap_min: assert property (p_gap_min) else $error("edge too early");
    property p_evt; ATTACH_EVT && !ATTACH_CLR |=> ATTACH_EVT; endproperty
    a_evt: assert property (p_evt) else $error("event flag lost");
endmodule

// ==== test/ccp_far_end.sv ====
`timescale 1ns/1ps
module ccp_far_end (
    // clock
    input wire logic clk,
    // line drive
    output logic drv,
    output logic lvl
);
    initial begin
        drv = 1'b0;
        lvl = 1'b1;
    end
    // bits go out lsb first; line released at the end so the bias returns
    task automatic send(input logic [7:0] bits, input int n);
        int i;
        @(negedge clk);
        drv = 1'b1;
        lvl = 1'b0;
        repeat (ccp_pkg::UI_CYC) @(negedge clk);
        for (i = 0; i < n; i++) begin
            lvl = ~lvl;
            repeat (ccp_pkg::HALF_CYC) @(negedge clk);
            if (bits[i]) begin
                lvl = ~lvl;
            end
            repeat (ccp_pkg::SECOND_CYC) @(negedge clk);
        end
        lvl = ~lvl;
        repeat (ccp_pkg::HALF_CYC) @(negedge clk);
        drv = 1'b0;
        lvl = ~lvl;
    endtask
endmodule

// ==== test/ccp_phy_top_test.sv ====
`timescale 1ns/1ps
module ccp_phy_top_test;
    logic MCLK = 1'b0;
    logic RESET, TX_VALID, TX_BIT, TX_LAST, VBUS_PRESENT, SINK_MODE, ATTACH_CLR, DETACH_CLR;
    logic [1:0] CC1_TERM, CC2_TERM, ADV_CURRENT_CFG, FAR_RP_LEVEL, RP_LEVEL, RP_INFERRED;
    logic [3:0] TX_PEAK_CFG, TX_PEAK_LEVEL, CONN_STATE;
    logic TX_READY, TX_BUSY, RX_VALID, RX_BIT, RX_ACTIVE, CC1_O, CC1_OE_N, CC2_O, CC2_OE_N;
    logic RD_PRESENT, VBUS_EN, VCONN_CC1_EN, VCONN_CC2_EN, ORIENT, ATTACH_EVT, DETACH_EVT;
    logic CC1_I, CC2_I, bias, far_drv, far_lvl, o_q, oe_q;
    logic rxq[$];
    int n_fail, cmp_count, ntog, n2;
    localparam logic [11:0] TAB [9] = '{12'h000, 12'h414, 12'h124, 12'h830, 12'h240,
        12'h956, 12'h665, 12'h570, 12'hA80};
    // a released line shows its bias, or on line two the far end's level while it drives
    assign CC1_I = !CC1_OE_N ? CC1_O : bias;
    assign CC2_I = !CC2_OE_N ? CC2_O : (far_drv ? far_lvl : bias);
    always #5 MCLK = ~MCLK;
    ccp_phy_top u_ccp_phy_top (.MCLK, .RESET, .TX_VALID, .TX_READY, .TX_BIT, .TX_LAST,
        .TX_BUSY, .RX_VALID, .RX_BIT, .RX_ACTIVE, .CC1_I, .CC1_O, .CC1_OE_N, .CC2_I, .CC2_O,
        .CC2_OE_N, .CC1_TERM, .CC2_TERM, .VBUS_PRESENT, .TX_PEAK_CFG, .ADV_CURRENT_CFG,
        .SINK_MODE, .FAR_RP_LEVEL, .TX_PEAK_LEVEL, .RP_LEVEL, .RD_PRESENT, .VBUS_EN,
        .VCONN_CC1_EN, .VCONN_CC2_EN, .ORIENT, .CONN_STATE, .RP_INFERRED, .ATTACH_EVT,
        .DETACH_EVT, .ATTACH_CLR, .DETACH_CLR);
    ccp_far_end u_ccp_far_end (.clk(MCLK), .drv(far_drv), .lvl(far_lvl));
    always @(posedge MCLK) begin
        if (RX_VALID === 1'b1) begin
            rxq.push_back(RX_BIT);
        end
        if (!CC1_OE_N && !oe_q && CC1_O !== o_q) begin
            ntog++;
        end
        if (CC2_OE_N === 1'b0) begin
            n2++;
        end
        o_q <= CC1_O;
        oe_q <= CC1_OE_N;
    end
    task chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task term(input logic [1:0] a, input logic [1:0] b);
        @(negedge MCLK);
        CC1_TERM = a;
        CC2_TERM = b;
        cyc(10);
    endtask
    task clr;
        @(negedge MCLK);
        ATTACH_CLR = 1'b1;
        DETACH_CLR = 1'b1;
        @(negedge MCLK);
        ATTACH_CLR = 1'b0;
        DETACH_CLR = 1'b0;
    endtask
    task t_attach;
        logic [11:0] e;
        for (int i = 0; i < 9; i++) begin
            e = TAB[i];
            term(e[11:10], e[9:8]);
            chk(CONN_STATE, e[7:4]);
            chk({VBUS_EN, VCONN_CC1_EN, VCONN_CC2_EN}, e[2:0]);
            chk(ATTACH_EVT, e[7:4] != 4'h0);
            clr();
            // accessories must end on losing just one line
            if (e[7:4] > 4'h6) begin
                term(2'h0, e[9:8]);
            end else begin
                term(2'h0, 2'h0);
            end
            chk(DETACH_EVT, e[7:4] != 4'h0);
            term(2'h0, 2'h0);
            clr();
        end
    endtask
    task t_tx;
        for (int i = 0; i < 16; i++) begin
            @(negedge MCLK);
            TX_VALID = 1'b1;
            TX_BIT = (i % 3 == 0);
            TX_LAST = (i == 15);
        end
        @(negedge MCLK);
        TX_VALID = 1'b0;
        chk(TX_READY, 1'b0);
        ntog = 0;
        n2 = 0;
        term(2'h1, 2'h0);
        chk(TX_BUSY, 1'b1);
        chk(ORIENT, 1'b0);
        for (int i = 0; i < 7000 && TX_BUSY !== 1'b0; i++) begin
            @(negedge MCLK);
        end
        chk(ntog, 23);
        chk(n2, 0);
        chk(CC1_OE_N, 1'b1);
        term(2'h0, 2'h0);
        clr();
    endtask
    task t_rx(input logic lose);
        logic [31:0] got;
        term(2'h0, 2'h1);
        chk(ORIENT, 1'b1);
        @(negedge MCLK);
        bias = !lose;
        cyc(700);
        rxq.delete();
        u_ccp_far_end.send(8'h0D, 4);
        chk(RX_ACTIVE, 1'b1);
        cyc(700);
        chk(RX_ACTIVE, 1'b0);
        chk(rxq.size(), lose ? 4 : 5);
        got = 0;
        foreach (rxq[k]) begin
            got = (got << 1) | rxq[k];
        end
        chk(got, 32'h0B);
        bias = 1'b1;
        term(2'h0, 2'h0);
        clr();
    endtask
    task t_cfg;
        @(negedge MCLK);
        TX_PEAK_CFG = 4'hA;
        cyc(2);
        chk(TX_PEAK_LEVEL, 4'hA);
        for (int i = 0; i < 3; i++) begin
            ADV_CURRENT_CFG = 2'(i);
            cyc(2);
            chk(RP_LEVEL, i);
        end
        SINK_MODE = 1'b1;
        FAR_RP_LEVEL = 2'h1;
        VBUS_PRESENT = 1'b1;
        cyc(10);
        chk({RD_PRESENT, RP_INFERRED}, 3'h5);
        chk(CONN_STATE, 4'h9);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge MCLK);
        n_fail++;
        close_out();
    end
    initial begin
        {RESET, bias} = 2'h3;
        {TX_VALID, TX_BIT, TX_LAST, VBUS_PRESENT, SINK_MODE, ATTACH_CLR, DETACH_CLR} = 7'h00;
        {CC1_TERM, CC2_TERM, ADV_CURRENT_CFG, FAR_RP_LEVEL, TX_PEAK_CFG} = 12'h000;
        cyc(2);
        RESET = 1'b0;
        cyc(1);
        chk({CC1_OE_N, CC2_OE_N, TX_READY, ATTACH_EVT, DETACH_EVT}, 5'h1C);
        chk(CONN_STATE, 4'h0);
        t_attach();
        t_tx();
        t_rx(1'b0);
        t_rx(1'b1);
        t_cfg();
        close_out();
    end
endmodule
bind ccp_phy_top ccp_phy_chk u_ccp_phy_chk (.MCLK, .RESET, .TX_BUSY, .CC1_O, .CC1_OE_N,
    .CC2_OE_N, .TX_PEAK_CFG, .TX_PEAK_LEVEL, .CONN_STATE, .VBUS_EN, .VCONN_CC1_EN,
    .VCONN_CC2_EN, .ATTACH_EVT, .ATTACH_CLR);
